// ### core/ilo_pkg.sv
// Package: encodings, widths and phase codes for the indexed-offset decoder
package ilo_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  // Operand at or below this value is an offset from the frame pointer
  localparam logic [7:0] OFFSET_MAX = 8'h5F;
  // Opcode field patterns
  localparam logic [5:0] OP_ADD_HI  = 6'h09;   // 0010 01
  localparam logic [7:0] OP_FILL_HI = 8'h68;   // 0110 1000
  localparam logic [3:0] OP_BSET_HI = 4'h8;    // 1000
  localparam logic [7:0] FILL_VALUE = 8'hFF;
  // Field positions
  localparam int DEST_BIT   = 9;
  localparam int ACCESS_BIT = 8;
  localparam int BITNO_LSB  = 9;
  // Status bit positions: N OV Z DC C
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_OV = 3;
  localparam int ST_N  = 4;
  localparam int ST_W  = 5;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [7:0] ACCUM_RESET  = 8'h00;
  typedef enum logic [3:0] {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } ilo_phase_t;
  typedef enum logic [1:0] {
    OPK_NONE = 2'h0,
    OPK_ADD  = 2'h1,
    OPK_BSET = 2'h2,
    OPK_FILL = 2'h3
  } ilo_op_t;
endpackage

// ### core/ilo_alu.sv
// Module: 8-bit adder with status generation for the indexed add
`timescale 1ns/1ps
module ilo_alu
  import ilo_pkg::*;
(
  // Operands
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] b,
  // Result and flags
  output logic      [DATA_W-1:0] sum,
  output logic      [ST_W-1:0]   flags
);
  logic [DATA_W:0] full;
  logic [4:0]      low;

  always_comb begin
    full            = {1'b0, a} + {1'b0, b};
    low             = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    sum             = full[DATA_W-1:0];
    flags           = '0;
    flags[ST_C]     = full[DATA_W];
    flags[ST_DC]    = low[4];
    flags[ST_Z]     = (full[DATA_W-1:0] == 8'h00);
    flags[ST_N]     = full[DATA_W-1];
    // Overflow: like-signed operands giving an opposite-signed result
    flags[ST_OV]    = (a[DATA_W-1] == b[DATA_W-1]) &&
                      (full[DATA_W-1] != a[DATA_W-1]);
  end
endmodule

// ### core/ilo_core.sv
// Module: indexed literal offset decode and execute for three operations
//
// Functional notes
// RULE_01 - With extension on, access operand up to 5Fh offsets frame pointer
// RULE_02 - Indexed add: accumulator plus frame byte, updates N OV C DC Z
// RULE_03 - Destination bit clear writes accumulator, set writes memory byte
// RULE_04 - One word, one cycle: decode, read, process, write quarters
// RULE_05 - Fill recognised by 0110 1000 then eight-bit offset
// RULE_06 - Fill writes FFh at frame pointer plus offset, flags unchanged
// RULE_07 - Fuse clear disables extended ops and offset addressing
// RULE_08 - Offset only when access bit 0 and operand at most 5Fh
// RULE_09 - Indexed bit set sets chosen bit, other bits and flags kept
`timescale 1ns/1ps
module ilo_core
  import ilo_pkg::*;
(
  // Clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  // Configuration
  input  wire logic              EXTENSION_ENABLE_FUSE,
  // Instruction fetch
  input  wire logic              INSTR_VALID,
  input  wire logic [WORD_W-1:0] INSTR_WORD,
  output logic                   INSTR_READY,
  // Address context
  input  wire logic [ADDR_W-1:0] STACK_FRAME_POINTER,
  input  wire logic [3:0]        BANK_SELECT,
  // Data memory
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic                   MEM_RD,
  input  wire logic [DATA_W-1:0] MEM_RDATA,
  output logic                   MEM_WR,
  output logic [DATA_W-1:0]      MEM_WDATA,
  // Core state
  output logic [DATA_W-1:0]      ACCUM,
  output logic [ST_W-1:0]        STATUS,
  output logic                   PHASE_WRITE,
  output logic                   UNSUPPORTED
);
  // ==========================================================
  // Decode helpers
  // ==========================================================
  function automatic ilo_op_t classify(input logic [WORD_W-1:0] w,
                                       input logic ext_on);
    classify = OPK_NONE;
    if (ext_on) begin // see RULE_07
      if (w[15:10] == OP_ADD_HI && !w[ACCESS_BIT]) begin // see RULE_02
        classify = OPK_ADD;
      end else if (w[15:8] == OP_FILL_HI) begin // see RULE_05
        classify = OPK_FILL;
      end else if (w[15:12] == OP_BSET_HI && !w[ACCESS_BIT]) begin
        classify = OPK_BSET; // see RULE_09
      end
    end
  endfunction

  function automatic logic [ADDR_W-1:0] eff_addr(
      input logic [7:0] f, input logic a_bit, input logic ext_on,
      input logic [ADDR_W-1:0] fp, input logic [3:0] bsr);
    if (a_bit) begin
      eff_addr = {bsr, f}; // see RULE_08
    end else if (ext_on && f <= OFFSET_MAX) begin
      eff_addr = fp + {4'h0, f}; // see RULE_01
    end else if (f <= OFFSET_MAX) begin
      eff_addr = {4'h0, f}; // see RULE_07
    end else begin
      eff_addr = {4'hF, f}; // see RULE_08
    end
  endfunction

  // ==========================================================
  // Quarter-phase sequencer
  // ==========================================================
  ilo_phase_t phase_q;
  ilo_phase_t phase_d;
  logic       busy_q;

  always_comb begin
    case (phase_q)
      PH_DECODE:  phase_d = (INSTR_VALID || busy_q) ? PH_READ : PH_DECODE;
      PH_READ:    phase_d = PH_PROCESS;
      PH_PROCESS: phase_d = PH_WRITE;
      PH_WRITE:   phase_d = PH_DECODE;
      default:    phase_d = PH_DECODE;
    endcase
  end

  // Four quarters per instruction, word taken only in decode
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      phase_q <= PH_DECODE;
    end else begin
      phase_q <= phase_d; // see RULE_04
    end
  end

  assign INSTR_READY = (phase_q == PH_DECODE);
  assign PHASE_WRITE = (phase_q == PH_WRITE);

  // ==========================================================
  // Instruction latch
  // ==========================================================
  logic [WORD_W-1:0] word_q;
  ilo_op_t           op_q;
  logic              unsup_q;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      word_q  <= '0;
      op_q    <= OPK_NONE;
      busy_q  <= 1'b0;
      unsup_q <= 1'b0;
    end else if (INSTR_READY && INSTR_VALID) begin
      word_q  <= INSTR_WORD;
      op_q    <= classify(INSTR_WORD, EXTENSION_ENABLE_FUSE);
      busy_q  <= 1'b1;
      unsup_q <= (classify(INSTR_WORD, EXTENSION_ENABLE_FUSE) == OPK_NONE);
    end else if (PHASE_WRITE) begin
      busy_q  <= 1'b0;
    end
  end

  assign UNSUPPORTED = unsup_q;

  // ==========================================================
  // Address, read and process
  // ==========================================================
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] operand_q;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result_q;
  logic [ST_W-1:0]   rflags_q;
  logic [DATA_W-1:0] sum;
  logic [ST_W-1:0]   aflags;
  logic [2:0]        bitno;

  assign bitno = word_q[BITNO_LSB+2:BITNO_LSB];

  // Write data is registered at the end of process, before the copy of
  // the read data exists, so process works on the live read data
  assign operand = (phase_q == PH_PROCESS) ? MEM_RDATA : operand_q;

  ilo_alu u_alu (
    .a     (ACCUM),
    .b     (operand),
    .sum   (sum),
    .flags (aflags)
  );

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      addr_q <= '0;
    end else if (phase_q == PH_READ) begin
      addr_q <= eff_addr(word_q[7:0], word_q[ACCESS_BIT],
                         EXTENSION_ENABLE_FUSE, STACK_FRAME_POINTER,
                         BANK_SELECT);
    end
  end

  // Memory read happens in process quarter against the settled address
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      operand_q <= '0;
    end else if (phase_q == PH_PROCESS) begin
      operand_q <= MEM_RDATA;
    end
  end

  always_comb begin
    MEM_ADDR = addr_q;
    MEM_RD   = (phase_q == PH_PROCESS) && (op_q != OPK_NONE);
  end

  always_comb begin
    result_q = operand;
    rflags_q = aflags;
    case (op_q)
      OPK_ADD:  result_q = sum; // see RULE_02
      OPK_BSET: result_q = operand | (8'h01 << bitno); // see RULE_09
      OPK_FILL: result_q = FILL_VALUE; // see RULE_06
      default:  result_q = operand;
    endcase
  end

  // ==========================================================
  // Write-back
  // ==========================================================
  logic to_mem;

  assign to_mem = (op_q == OPK_BSET) || (op_q == OPK_FILL) ||
                  ((op_q == OPK_ADD) && word_q[DEST_BIT]); // see RULE_03

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      MEM_WR    <= 1'b0;
      MEM_WDATA <= '0;
    end else begin
      MEM_WR    <= (phase_q == PH_PROCESS) && to_mem; // see RULE_04
      MEM_WDATA <= result_q;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ACCUM <= ACCUM_RESET;
    end else if (PHASE_WRITE && op_q == OPK_ADD && !word_q[DEST_BIT]) begin
      ACCUM <= sum; // see RULE_03
    end
  end

  // Only the add touches status; fill and bit set leave it alone
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      STATUS <= STATUS_RESET;
    end else if (PHASE_WRITE && op_q == OPK_ADD) begin
      STATUS <= rflags_q; // see RULE_02
    end
  end
endmodule

// ### tb/ilo_core_sva.sv
// Checker: timing and write rules of the indexed-offset decoder
`timescale 1ns/1ps
module ilo_core_sva
  import ilo_pkg::*;
(
  // Clock and reset
  input wire logic              CORE_CLK,
  input wire logic              RESET,
  // Observed ports
  input wire logic              EXTENSION_ENABLE_FUSE,
  input wire logic              INSTR_VALID,
  input wire logic [WORD_W-1:0] INSTR_WORD,
  input wire logic              INSTR_READY,
  input wire logic [ADDR_W-1:0] STACK_FRAME_POINTER,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic              MEM_WR,
  input wire logic [DATA_W-1:0] MEM_WDATA,
  input wire logic [ST_W-1:0]   STATUS,
  input wire logic              PHASE_WRITE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic tk, fl, bs;
  assign tk = INSTR_READY && INSTR_VALID;
  assign fl = tk && EXTENSION_ENABLE_FUSE && INSTR_WORD[15:8] == OP_FILL_HI;
  assign bs = tk && EXTENSION_ENABLE_FUSE && !INSTR_WORD[ACCESS_BIT] &&
              INSTR_WORD[15:12] == OP_BSET_HI;
  a_take_to_write: assert property (tk |-> ##3 PHASE_WRITE)
    else $error("write quarter not three cycles after take");
  a_write_one_cycle: assert property (MEM_WR |=> !MEM_WR)
    else $error("memory write longer than one cycle");
  a_fill_ones: assert property (
    fl |-> ##3 MEM_WR && MEM_WDATA == FILL_VALUE)
    else $error("fill did not write all ones");
  a_fill_flags: assert property (
    fl |-> ##4 STATUS == $past(STATUS, 4))
    else $error("fill changed status");
  a_bset_flags: assert property (
    bs |-> ##4 STATUS == $past(STATUS, 4))
    else $error("bit set changed status");
  a_fuse_off: assert property (
    tk && !EXTENSION_ENABLE_FUSE |-> ##3 !MEM_WR)
    else $error("write with extension off");
  a_offset_addr: assert property (
    fl && INSTR_WORD[7:0] <= OFFSET_MAX |->
    ##2 MEM_ADDR == $past(STACK_FRAME_POINTER) + $past(INSTR_WORD[7:0], 2))
    else $error("indexed address wrong");
  a_plain_addr: assert property (
    fl && INSTR_WORD[7:0] > OFFSET_MAX |->
    ##2 MEM_ADDR == {4'hF, $past(INSTR_WORD[7:0], 2)})
    else $error("access bank address wrong");
  a_add_to_accum: assert property (tk && INSTR_WORD[15:9] == 7'h12 |->
    ##3 PHASE_WRITE && !MEM_WR)
    else $error("accumulator add wrote memory");
endmodule
bind ilo_core ilo_core_sva ilo_core_sva_i (.CORE_CLK, .RESET,
  .EXTENSION_ENABLE_FUSE, .INSTR_VALID, .INSTR_WORD, .INSTR_READY,
  .STACK_FRAME_POINTER, .MEM_ADDR, .MEM_WR, .MEM_WDATA, .STATUS,
  .PHASE_WRITE);

// ### tb/indexed_literal_offset_decode_bench.sv
// Testbench: directed scenarios for the indexed-offset decoder
`timescale 1ns/1ps
module indexed_literal_offset_decode_bench
  import ilo_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, fuse = 1'b1, valid = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [11:0] fp = 12'h000, ad_s;
  logic [7:0]  rdata = 8'h00, wdata, accum, wd_s;
  logic [4:0]  status;
  logic [11:0] addr;
  logic        rdy, rd, wr, pw, uns, wr_s;
  logic [3:0]  bank = 4'h0, rd_n;
  int          n_fail = 0, n_tests = 0;
  always #10 clk = ~clk;
  ilo_core ilo_core_i (.CORE_CLK(clk), .RESET(rst),
    .EXTENSION_ENABLE_FUSE(fuse), .INSTR_VALID(valid), .INSTR_WORD(word),
    .INSTR_READY(rdy), .STACK_FRAME_POINTER(fp), .BANK_SELECT(bank),
    .MEM_ADDR(addr), .MEM_RD(rd), .MEM_RDATA(rdata), .MEM_WR(wr),
    .MEM_WDATA(wdata), .ACCUM(accum), .STATUS(status), .PHASE_WRITE(pw),
    .UNSUPPORTED(uns));
  // ==========================================================
  // Shared tasks
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Context held for the whole word, since the core samples it late
  task run(input logic [15:0] w, input logic f, input logic [7:0] d);
    int i;
    i = 0;
    rd_n = 4'h0;
    @(posedge clk);
    word <= w; fuse <= f; fp <= 12'hA00; rdata <= d; valid <= 1'b1;
    #1;
    while (rdy !== 1'b1 && i < 8) begin @(posedge clk); #1; i++; end
    // Taking edge: ready was seen high before it
    @(posedge clk);
    valid <= 1'b0;
    do begin
      @(posedge clk); #1; i++;
      if (rd === 1'b1) rd_n++;
    end while (pw !== 1'b1 && i < 16);
    if (pw !== 1'b1) begin n_fail++; finish_test; end
    wr_s = wr; wd_s = wdata; ad_s = addr;
    @(posedge clk); #1;
  endtask
  // ==========================================================
  // Scenarios
  task t_add;
    run(16'h262C, 1'b1, 8'h20);
    chk(ad_s, 12'hA2C);
    chk(wr_s, 1'b1);
    chk(wd_s, 8'h20);
    chk(accum, 8'h00);
    run(16'h242C, 1'b1, 8'h17);
    chk(wr_s, 1'b0);
    chk(accum, 8'h17);
    run(16'h242C, 1'b1, 8'h20);
    chk(accum, 8'h37);
    // Wraps to zero: carry, digit carry and zero all set
    run(16'h242C, 1'b1, 8'hC9);
    chk(accum, 8'h00);
    chk(status, 5'h07);
    $display("add test done");
  endtask
  task t_bset;
    for (int b = 0; b < 8; b++) begin
      run({4'h8, b[2:0], 1'b0, 8'h0A}, 1'b1, 8'h55);
      chk(ad_s, 12'hA0A);
      chk(wd_s, 8'h55 | (8'h01 << b));
      chk(status, 5'h07);
    end
    $display("bit set test done");
  endtask
  task t_fill;
    run(16'h685F, 1'b1, 8'h00);
    chk(ad_s, 12'hA5F);
    chk(wr_s, 1'b1);
    chk(rd_n, 4'h1);
    chk(wd_s, 8'hFF);
    chk(status, 5'h07);
    chk(uns, 1'b0);
    $display("fill test done");
  endtask
  task t_wide;
    run(16'h2660, 1'b1, 8'h01);
    chk(ad_s, 12'hF60);
    chk(wd_s, 8'h01);
    run(16'h6860, 1'b1, 8'h00);
    chk(ad_s, 12'hF60);
    chk(wd_s, 8'hFF);
    bank <= 4'h3;
    run(16'h272C, 1'b1, 8'h00);
    chk(ad_s, 12'h32C);
    chk(wr_s, 1'b0);
    chk(uns, 1'b1);
    $display("plain address test done");
  endtask
  task t_fuse;
    run(16'h685F, 1'b0, 8'h00);
    chk(wr_s, 1'b0);
    chk(uns, 1'b1);
    chk(ad_s, 12'h05F);
    chk(rd_n, 4'h0);
    run(16'h262C, 1'b0, 8'h00);
    chk(wr_s, 1'b0);
    $display("fuse off test done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_add;
    t_bset;
    t_fill;
    t_wide;
    t_fuse;
    finish_test;
  end
endmodule
